// File: verilog/rms_defs.vh
`ifndef RMS_DEFS_VH
`define RMS_DEFS_VH
// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define RMS_ADDR_CTRL 12'h000
`define RMS_ADDR_STATUS 12'h004
`define RMS_ADDR_RATE 12'h008
`define RMS_ADDR_OVLD 12'h00C
`define RMS_ADDR_TALLY 12'h010
`define RMS_ADDR_HEADS 12'h014
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RMS_CTRL_ENABLE 0
`define RMS_CTRL_TICK 1
`define RMS_CTRL_CLR_DONE 2
`define RMS_CTRL_RESET 32'h0000_0001
// ------------------------------------------------------------
// times in microseconds, clock in MHz
// ------------------------------------------------------------
`define RMS_CLK_MHZ 100
`define RMS_STANDBY_US 20000
`define RMS_CMD_US 20000
`define RMS_WINDOW_US 100000
`define RMS_SCALE_US 11000
`define RMS_STROBE_US 2000
`define RMS_INHIBIT_US 13000
`define RMS_TICK_US 5000000
`define RMS_TICKS_PER_MIN 12
`define RMS_MIN_PER_MARK 12
`define RMS_TALLY_MOD 12
`endif

// File: verilog/rms_sequencer.v
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rms_defs.vh"
module rms_sequencer #(
	parameter integer TICK_CYC = `RMS_TICK_US * `RMS_CLK_MHZ,
	parameter integer STANDBY_CYC = `RMS_STANDBY_US * `RMS_CLK_MHZ,
	parameter integer CMD_CYC = `RMS_CMD_US * `RMS_CLK_MHZ,
	parameter integer WINDOW_CYC = `RMS_WINDOW_US * `RMS_CLK_MHZ,
	parameter integer SCALE_CYC = `RMS_SCALE_US * `RMS_CLK_MHZ,
	parameter integer STROBE_CYC = `RMS_STROBE_US * `RMS_CLK_MHZ,
	parameter integer INHIBIT_CYC = `RMS_INHIBIT_US * `RMS_CLK_MHZ
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// event sources, one-cycle pulses
	input wire good_gas_evt,
	input wire good_crystal_evt,
	input wire high_crystal_evt,
	input wire high_plastic_evt,
	input wire [5:0] event_code,
	// tape heads and status
	output reg [15:0] tape_heads,
	output reg tape_strobe,
	output reg scaler_clear,
	output reg event_inhibit,
	output reg high_window,
	output reg rate_select_n,
	output reg [4:0] mode_active
);
	// ------------------------------------------------------------
	// modes (one-hot), index 0..4
	// ------------------------------------------------------------
	localparam [4:0] M_IDLE = 5'h00;
	localparam [4:0] M_CRYSTAL = 5'h01;
	localparam [4:0] M_GAS = 5'h02;
	localparam [4:0] M_RATE = 5'h04;
	localparam [4:0] M_OVLD = 5'h08;
	localparam [4:0] M_MARK = 5'h10;
	// generator states
	localparam [2:0] G_IDLE = 3'b001;
	localparam [2:0] G_SCALE = 3'b010;
	localparam [2:0] G_STROBE = 3'b100;

	// mode index on the top three head tracks, the one-hot word does not fit
	function [2:0] mode_code;
		input [4:0] m;
		begin
			if (m[4]) mode_code = 3'h4;
			else if (m[3]) mode_code = 3'h3;
			else if (m[2]) mode_code = 3'h2;
			else if (m[1]) mode_code = 3'h1;
			else mode_code = 3'h0;
		end
	endfunction

	function [5:0] sat_inc;
		input [5:0] v;
		begin
			sat_inc = (v == 6'h3F) ? v : v + 6'h01;
		end
	endfunction

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg enable_q;
	reg ext_tick_q;
	reg done_q;
	reg [31:0] tick_cnt_q;
	reg [3:0] min_div_q;
	reg [3:0] mark_div_q;
	reg [5:0] tally_q;
	reg hi_pend_q;
	reg mark_pend_q;
	reg [31:0] standby_q;
	reg [31:0] cmd_q;
	reg [31:0] win_q;
	reg [31:0] gen_q;
	reg [31:0] inh_q;
	reg [2:0] gen_st_q;
	reg [5:0] rate_gas_q;
	reg [5:0] rate_cry_q;
	reg [5:0] ovl_cry_q;
	reg [5:0] ovl_pla_q;
	reg [5:0] scal_a_q;
	reg [5:0] scal_b_q;
	reg wr_ctrl;
	reg [31:0] wdat;
	reg aw_held;
	reg w_held;
	reg [11:0] aw_q;

	wire tick_hw = (tick_cnt_q == TICK_CYC - 1);
	wire tick = enable_q & (tick_hw | ext_tick_q);
	wire min_tick = tick & (min_div_q == `RMS_TICKS_PER_MIN - 1);
	wire mark_tick = min_tick & (mark_div_q == `RMS_MIN_PER_MARK - 1);
	wire cmd_busy = (cmd_q != 0);
	wire cmd_end = (cmd_q == 1);
	wire win_end = (win_q == 1);
	wire busy = (mode_active != M_IDLE) | (inh_q != 0) | cmd_busy | (win_q != 0);
	wire accept_cry = good_crystal_evt & ~good_gas_evt & ~busy & enable_q;
	wire accept_gas = good_gas_evt & ~good_crystal_evt & ~busy & enable_q;
	wire start_rate = (standby_q != 0) & ~busy;
	wire gen_trig = accept_cry | accept_gas | start_rate | win_end
		| (cmd_end & mode_active[3] & mark_pend_q);

	// ------------------------------------------------------------
	// pacing: five-second tick, minute and twelve-minute dividers
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_q <= 32'h0000_0000;
			min_div_q <= 4'h0;
			mark_div_q <= 4'h0;
			tally_q <= 6'h00;
			hi_pend_q <= 1'b0;
			mark_pend_q <= 1'b0;
			standby_q <= 32'h0000_0000;
		end else begin
			tick_cnt_q <= tick_hw ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
			if (tick) begin
				min_div_q <= (min_div_q == `RMS_TICKS_PER_MIN - 1) ? 4'h0 : min_div_q + 4'h1;
			end
			if (min_tick) begin
				mark_div_q <= (mark_div_q == `RMS_MIN_PER_MARK - 1) ? 4'h0 : mark_div_q + 4'h1;
			end
			if (mark_tick) begin
				tally_q <= (tally_q == `RMS_TALLY_MOD - 1) ? 6'h00 : tally_q + 6'h01;
			end
			// set wins over clear for both pending flags
			if (min_tick) begin
				hi_pend_q <= 1'b1;
			end else if (win_end) begin
				hi_pend_q <= 1'b0;
			end
			if (mark_tick) begin
				mark_pend_q <= 1'b1;
			end else if (cmd_end & mode_active[4]) begin
				mark_pend_q <= 1'b0;
			end
			if (tick) begin
				standby_q <= STANDBY_CYC;
			end else if (start_rate) begin
				standby_q <= 32'h0000_0000;
			end else if (standby_q != 0) begin
				standby_q <= standby_q - 32'h0000_0001;
			end
		end
	end

	// ------------------------------------------------------------
	// mode sequencing and dump commands
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			mode_active <= M_IDLE;
			cmd_q <= 32'h0000_0000;
			win_q <= 32'h0000_0000;
			high_window <= 1'b0;
			rate_select_n <= 1'b1;
			done_q <= 1'b0;
		end else begin
			if (accept_cry) begin
				mode_active <= M_CRYSTAL;
			end else if (accept_gas) begin
				mode_active <= M_GAS;
			end else if (start_rate) begin
				mode_active <= M_RATE;
				cmd_q <= CMD_CYC;
			end else if (win_end) begin
				mode_active <= M_OVLD;
				cmd_q <= CMD_CYC;
			end else if (cmd_end & mode_active[2] & hi_pend_q) begin
				mode_active <= M_IDLE;
				cmd_q <= 32'h0000_0000;
				win_q <= WINDOW_CYC;
			end else if (cmd_end & mode_active[3] & mark_pend_q) begin
				mode_active <= M_MARK;
				cmd_q <= CMD_CYC;
			end else if (cmd_end) begin
				mode_active <= M_IDLE;
				cmd_q <= 32'h0000_0000;
			end else if (cmd_busy) begin
				cmd_q <= cmd_q - 32'h0000_0001;
			end else if (mode_active[1:0] != 2'b00 && gen_st_q == G_IDLE && inh_q == 0) begin
				mode_active <= M_IDLE;
			end
			if (win_q != 0) begin
				win_q <= win_q - 32'h0000_0001;
			end
			high_window <= (win_q > 1) | (cmd_end & mode_active[2] & hi_pend_q);
			rate_select_n <= ~(start_rate | (cmd_busy & ~cmd_end & mode_active[2]));
			if (cmd_end & mode_active[2]) begin
				done_q <= 1'b1;
			end else if (wr_ctrl & wdat[`RMS_CTRL_CLR_DONE]) begin
				done_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// accumulators
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			rate_gas_q <= 6'h00;
			rate_cry_q <= 6'h00;
			ovl_cry_q <= 6'h00;
			ovl_pla_q <= 6'h00;
		end else begin
			if (cmd_end & mode_active[2]) begin
				rate_gas_q <= 6'h00;
				rate_cry_q <= 6'h00;
			end else begin
				if (accept_gas) rate_gas_q <= sat_inc(rate_gas_q);
				if (accept_cry) rate_cry_q <= sat_inc(rate_cry_q);
			end
			if (cmd_end & mode_active[3]) begin
				ovl_cry_q <= 6'h00;
				ovl_pla_q <= 6'h00;
			end else if (win_q != 0) begin
				if (high_crystal_evt) ovl_cry_q <= sat_inc(ovl_cry_q);
				if (high_plastic_evt) ovl_pla_q <= sat_inc(ovl_pla_q);
			end
		end
	end

	// ------------------------------------------------------------
	// timing generator: scale, strobe, clear, inhibit
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			gen_st_q <= G_IDLE;
			gen_q <= 32'h0000_0000;
			inh_q <= 32'h0000_0000;
			event_inhibit <= 1'b0;
			tape_strobe <= 1'b0;
			scaler_clear <= 1'b0;
			tape_heads <= 16'h0000;
			scal_a_q <= 6'h00;
			scal_b_q <= 6'h00;
		end else begin
			scaler_clear <= 1'b0;
			if (gen_trig) begin
				inh_q <= INHIBIT_CYC - 1;
			end else if (inh_q != 0) begin
				inh_q <= inh_q - 32'h0000_0001;
			end
			event_inhibit <= gen_trig | (inh_q != 0) | cmd_busy;
			case (gen_st_q)
			G_IDLE: begin
				if (gen_trig) begin
					gen_st_q <= G_SCALE;
					gen_q <= SCALE_CYC - 1;
					// load scalers with what this cycle reports
					if (accept_cry | accept_gas) begin
						scal_a_q <= event_code;
						scal_b_q <= 6'h00;
					end else if (start_rate) begin
						scal_a_q <= rate_cry_q;
						scal_b_q <= rate_gas_q;
					end else if (win_end) begin
						scal_a_q <= ovl_cry_q;
						scal_b_q <= ovl_pla_q;
					end else begin
						scal_a_q <= tally_q;
						scal_b_q <= 6'h00;
					end
				end
			end
			G_SCALE: begin
				if (gen_q == 0) begin
					gen_st_q <= G_STROBE;
					gen_q <= STROBE_CYC - 1;
					tape_strobe <= 1'b1;
					tape_heads <= {mode_code(mode_active), scal_b_q, 1'b1, scal_a_q};
				end else begin
					gen_q <= gen_q - 32'h0000_0001;
				end
			end
			G_STROBE: begin
				if (gen_q == 0) begin
					gen_st_q <= G_IDLE;
					tape_strobe <= 1'b0;
					tape_heads <= 16'h0000;
					scaler_clear <= 1'b1;
					scal_a_q <= 6'h00;
					scal_b_q <= 6'h00;
				end else begin
					gen_q <= gen_q - 32'h0000_0001;
				end
			end
			default: gen_st_q <= G_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// axi4-lite slave, one-cycle write and read responses
	// ------------------------------------------------------------
	wire aw_ok = aw_held | s_axi_awvalid;
	wire w_ok = w_held | s_axi_wvalid;
	wire [11:0] aw_use = aw_held ? aw_q : s_axi_awaddr;
	wire do_wr = aw_ok & w_ok & ~s_axi_bvalid;

	always @* begin
		wr_ctrl = do_wr & (aw_use == `RMS_ADDR_CTRL) & s_axi_wstrb[0];
		wdat = s_axi_wdata;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h0000_0000;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_q <= 12'h000;
			enable_q <= 1'b1;
			ext_tick_q <= 1'b0;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
			ext_tick_q <= 1'b0;
			if (s_axi_awvalid & ~aw_held & ~s_axi_awready & ~do_wr) begin
				aw_held <= 1'b1;
				aw_q <= s_axi_awaddr;
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid & ~w_held & ~s_axi_wready & ~do_wr) begin
				w_held <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (do_wr) begin
				s_axi_awready <= ~aw_held;
				s_axi_wready <= ~w_held;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_use == `RMS_ADDR_CTRL) ? 2'b00 : 2'b10;
				if (wr_ctrl) begin
					enable_q <= s_axi_wdata[`RMS_CTRL_ENABLE];
					ext_tick_q <= s_axi_wdata[`RMS_CTRL_TICK];
				end
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				if (s_axi_araddr == `RMS_ADDR_CTRL) begin
					s_axi_rdata <= {31'h0000_0000, enable_q};
				end else if (s_axi_araddr == `RMS_ADDR_STATUS) begin
					s_axi_rdata <= {20'h0_0000, done_q, mark_pend_q, hi_pend_q, event_inhibit,
						gen_st_q, mode_active};
				end else if (s_axi_araddr == `RMS_ADDR_RATE) begin
					s_axi_rdata <= {20'h0_0000, rate_gas_q, rate_cry_q};
				end else if (s_axi_araddr == `RMS_ADDR_OVLD) begin
					s_axi_rdata <= {20'h0_0000, ovl_pla_q, ovl_cry_q};
				end else if (s_axi_araddr == `RMS_ADDR_TALLY) begin
					s_axi_rdata <= {26'h000_0000, tally_q};
				end else if (s_axi_araddr == `RMS_ADDR_HEADS) begin
					s_axi_rdata <= {16'h0000, tape_heads};
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // rms_sequencer

// File: testbench/rms_seq_asserts.sv
`timescale 1ns/1ps
module rms_seq_asserts #(
	parameter integer SCALE_CYC = 22,
	parameter integer STROBE_CYC = 4,
	parameter integer INHIBIT_CYC = 26
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// events
	input wire good_gas_evt,
	input wire good_crystal_evt,
	// readout side
	input wire tape_strobe,
	input wire scaler_clear,
	input wire event_inhibit,
	input wire high_window,
	input wire rate_select_n,
	input wire [4:0] mode_active
);
	localparam int SC_LO = SCALE_CYC - 1;
	localparam int SC_HI = SCALE_CYC + 2;
	logic [15:0] str_q;
	logic [15:0] inh_q;
	// ----------------------------------------
	// run lengths of strobe and inhibit
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			str_q <= 16'h0000;
			inh_q <= 16'h0000;
		end else begin
			str_q <= tape_strobe ? str_q + 16'h0001 : 16'h0000;
			inh_q <= event_inhibit ? inh_q + 16'h0001 : 16'h0000;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_one_mode: assert property ($onehot0(mode_active))
		else $error("more than one mode active");
	a_evt_accept: assert property (good_crystal_evt && !good_gas_evt && !event_inhibit
		&& !high_window && mode_active == 5'h00 |=> mode_active == 5'h01 && event_inhibit)
		else $error("crystal event not taken as mode zero");
	a_evt_blocked: assert property (mode_active[2] && good_gas_evt |=> !mode_active[1])
		else $error("event taken during rate dump");
	a_scale_time: assert property ($rose(event_inhibit) |-> ##[SC_LO:SC_HI] $rose(tape_strobe))
		else $error("strobe not after scaling period");
	a_strobe_len: assert property ($fell(tape_strobe) |-> str_q == STROBE_CYC)
		else $error("write strobe width wrong");
	a_clear_end: assert property ($fell(tape_strobe) |-> ##[0:1] scaler_clear)
		else $error("no scaler clear at strobe end");
	a_clear_pulse: assert property (scaler_clear |=> !scaler_clear)
		else $error("scaler clear longer than one cycle");
	a_inhibit_len: assert property ($fell(event_inhibit) |-> inh_q >= INHIBIT_CYC)
		else $error("inhibit ended early");
	a_select_blocks: assert property (!rate_select_n && $past(!rate_select_n) |-> event_inhibit)
		else $error("events open during rate dump command");
	a_window_ovld: assert property ($fell(high_window) |-> ##[0:2] mode_active[3])
		else $error("no overload dump after window");
	c_rate: cover property ($rose(mode_active[2]));
	c_ovld: cover property ($rose(mode_active[3]));
	c_mark: cover property ($rose(mode_active[4]));
endmodule // rms_seq_asserts
bind rms_sequencer rms_seq_asserts #(.SCALE_CYC(SCALE_CYC), .STROBE_CYC(STROBE_CYC),
	.INHIBIT_CYC(INHIBIT_CYC)) i_chk (.aclk(aclk), .aresetn(aresetn),
	.good_gas_evt(good_gas_evt), .good_crystal_evt(good_crystal_evt),
	.tape_strobe(tape_strobe), .scaler_clear(scaler_clear), .event_inhibit(event_inhibit),
	.high_window(high_window), .rate_select_n(rate_select_n), .mode_active(mode_active));

// File: testbench/rms_tape_model.sv
`timescale 1ns/1ps
module rms_tape_model (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// write heads
	input wire [15:0] tape_heads,
	input wire tape_strobe,
	// what was written
	output logic [7:0] frames,
	output logic [7:0] smear,
	output logic [15:0] last_word
);
	logic strobe_q;
	// heads must not move while the strobe writes, or the frame smears
	always @(posedge aclk) begin
		if (!aresetn) begin
			frames <= 8'h00;
			smear <= 8'h00;
			strobe_q <= 1'b0;
			last_word <= 16'h0000;
		end else begin
			strobe_q <= tape_strobe;
			if (tape_strobe && !strobe_q) begin
				frames <= frames + 8'h01;
				last_word <= tape_heads;
			end
			if (tape_strobe && strobe_q && tape_heads !== last_word)
				smear <= smear + 8'h01;
		end
	end
endmodule // rms_tape_model

// File: testbench/rms_sequencer_tb.sv
`timescale 1ns/1ps
`include "rms_defs.vh"
module rms_sequencer_tb;
	logic aclk = 0, aresetn = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 0;
	logic gas = 0, crys = 0, hcrys = 0, hplas = 0;
	logic [5:0] code = 0;
	wire awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] heads, last_word;
	wire strobe, sclr, inhibit, hwin, rsel_n;
	wire [4:0] mode;
	wire [7:0] frames, smear;
	int mismatches = 0, compares = 0;
	logic [31:0] d;
	logic [1:0] r;
	always #5 aclk = ~aclk;
	rms_sequencer #(.TICK_CYC(200), .STANDBY_CYC(40), .CMD_CYC(40), .WINDOW_CYC(100),
		.SCALE_CYC(22), .STROBE_CYC(4), .INHIBIT_CYC(26)) i_dut (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.good_gas_evt(gas), .good_crystal_evt(crys), .high_crystal_evt(hcrys),
		.high_plastic_evt(hplas), .event_code(code), .tape_heads(heads),
		.tape_strobe(strobe), .scaler_clear(sclr), .event_inhibit(inhibit),
		.high_window(hwin), .rate_select_n(rsel_n), .mode_active(mode));
	rms_tape_model i_tape (.aclk(aclk), .aresetn(aresetn), .tape_heads(heads),
		.tape_strobe(strobe), .frames(frames), .smear(smear), .last_word(last_word));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 0;
	endtask
	task rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		v = rdata;
		rs = rresp;
		rready <= 0;
	endtask
	task pulse(input logic g, input logic c);
		gas <= g;
		crys <= c;
		@(posedge aclk);
		gas <= 0;
		crys <= 0;
		@(posedge aclk);
	endtask
	// w 0..4 is a mode bit, 5 the high window
	task wait_sig(input int w);
		int n;
		n = 0;
		while ((w < 5 ? mode[w] : hwin) !== 1'b1 && n < 40000) begin
			@(posedge aclk);
			n++;
		end
		chk(n < 40000, 1);
	endtask
	task wait_idle;
		int n;
		n = 0;
		while ((mode !== 5'h00 || inhibit !== 1'b0) && n < 2000) begin
			@(posedge aclk);
			n++;
		end
		chk(n < 2000, 1);
	endtask
	initial begin
		repeat (80000) @(posedge aclk);
		$display("watchdog ran out");
		mismatches++;
		close_out();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(`RMS_ADDR_TALLY, d, r);
		chk(d, 32'h0000_0000);
		chk(rsel_n, 1);
		rd(12'h020, d, r);
		chk({30'h0, r}, 32'h0000_0002);
		$display("test reset done");
		wait_sig(2);
		@(posedge aclk);
		chk(rsel_n, 0);
		pulse(1, 0);
		chk(mode, 5'h04);
		wait_idle();
		rd(`RMS_ADDR_STATUS, d, r);
		chk(d[11], 1);
		wr(`RMS_ADDR_CTRL, 32'h0000_0005, r);
		rd(`RMS_ADDR_STATUS, d, r);
		chk(d[11], 0);
		$display("test rate dump done");
		code <= 6'h2a;
		pulse(0, 1);
		chk(mode, 5'h01);
		chk(inhibit, 1);
		pulse(1, 0);
		chk(mode, 5'h01);
		wait_idle();
		chk(frames, 8'h02);
		pulse(1, 0);
		chk(mode, 5'h02);
		wait_idle();
		pulse(1, 1);
		chk(mode, 5'h00);
		$display("test events done");
		wait_sig(5);
		hcrys <= 1;
		hplas <= 1;
		@(posedge aclk);
		hcrys <= 0;
		hplas <= 0;
		wait_sig(3);
		chk(hwin, 0);
		rd(`RMS_ADDR_OVLD, d, r);
		chk(d, 32'h0000_0041);
		rd(`RMS_ADDR_STATUS, d, r);
		chk(d[9], 0);
		$display("test overload done");
		wait_sig(4);
		wait_idle();
		rd(`RMS_ADDR_TALLY, d, r);
		chk(d, 32'h0000_0001);
		rd(`RMS_ADDR_STATUS, d, r);
		chk(d[10], 0);
		chk(smear, 8'h00);
		$display("test marker done");
		close_out();
	end
endmodule // rms_sequencer_tb
